// ===== wcd_pkg.sv
// Constants, register map and state type of the word copy DMA engine.
// Assumes a 32-bit APB target bus and 32-bit AHB-Lite and APB initiators.
`default_nettype none

package wcd_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] WCD_BLOCK_OFFSET = 32'h0800_0000;
  localparam int          WCD_REG_AW       = 5;
  localparam logic [4:0]  WCD_OFF_CONTROL  = 5'h00;
  localparam logic [4:0]  WCD_OFF_IRQ_CFG  = 5'h04;
  localparam logic [4:0]  WCD_OFF_STATE    = 5'h08;
  localparam logic [4:0]  WCD_OFF_SOURCE   = 5'h0C;
  localparam logic [4:0]  WCD_OFF_DEST     = 5'h10;
  localparam logic [4:0]  WCD_OFF_COUNT    = 5'h14;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          WCD_BIT_GO       = 0;
  localparam int          WCD_BIT_ABORT    = 1;
  localparam int          WCD_BIT_IRQ_ALL  = 0;
  localparam int          WCD_BIT_BUSY     = 0;
  localparam int          WCD_BIT_ERROR    = 1;
  localparam logic [1:0]  WCD_CTRL_RESET   = 2'h0;
  localparam logic [1:0]  WCD_IRQC_RESET   = 2'h0;
  localparam logic [31:0] WCD_WORD_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0]  WCD_HTRANS_IDLE   = 2'h0;
  localparam logic [1:0]  WCD_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  WCD_HSIZE_WORD    = 3'h2;
  localparam logic [2:0]  WCD_HBURST_SINGLE = 3'h0;
  localparam logic [31:0] WCD_ADDR_STEP     = 32'h0000_0004;
  localparam logic [31:0] WCD_ONE_WORD      = 32'h0000_0001;

  // ----------------------------------------------------------------------
  // Copy sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    WCD_IDLE       = 7'b000_0001,
    WCD_RD_ADDR    = 7'b000_0010,
    WCD_RD_DATA    = 7'b000_0100,
    WCD_WR_ADDR    = 7'b000_1000,
    WCD_WR_DATA    = 7'b001_0000,
    WCD_TCM_SETUP  = 7'b010_0000,
    WCD_TCM_ACCESS = 7'b100_0000
  } wcd_state_t;

endpackage

`default_nettype wire

// ===== wcd_word_copy_dma.sv
// Word copy DMA engine: APB register target, AHB-Lite source reader and
// either an AHB-Lite or a tightly coupled memory APB destination writer.
// Assumes all buses run on clk_sys; the surrounding logic halts the hart
// and unblocks the memory port before the APB destination is used.
//
// Behaviour
// - Busy output high while a copy runs.
// - Interrupt output signals end of copy.
// - Source words read over AHB-Lite initiator.
// - AHB-Lite destination writes each word.
// - Memory-port destination writes each word over APB.
// - Registers reached only through APB target.
// - Decode at base plus block offset.
// - Control bit 0 starts a copy.
// - Control bit 1 abandons the copy.
// - Config bit set: interrupt on error and completion.
// - Config bit clear: interrupt on error only.
// - Status has two read-only flags.
// - Status bit 1 flags last copy error.
// - Status bit 0 reads busy.
// - Source start address register, 32 bits.
// - Destination start address register, 32 bits.
// - Size register counts words moved exactly.
// - Build choice selects destination port.
`default_nettype none
`timescale 1ns/1ps

module wcd_word_copy_dma
  import wcd_pkg::*;
#(
  parameter int          WRITE_PORT = 1,
  parameter logic [31:0] ESS_BASE   = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Register target
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Source read port
  output var  logic [31:0] src_haddr,
  output var  logic [1:0]  src_htrans,
  output var  logic        src_hwrite,
  output var  logic [2:0]  src_hsize,
  output var  logic [2:0]  src_hburst,
  input  wire logic [31:0] src_hrdata,
  input  wire logic        src_hready,
  input  wire logic        src_hresp,
  // Destination write port
  output var  logic [31:0] dst_haddr,
  output var  logic [1:0]  dst_htrans,
  output var  logic        dst_hwrite,
  output var  logic [2:0]  dst_hsize,
  output var  logic [2:0]  dst_hburst,
  output var  logic [31:0] dst_hwdata,
  input  wire logic        dst_hready,
  input  wire logic        dst_hresp,
  // Tightly coupled memory write port
  output var  logic [31:0] tcm_paddr,
  output var  logic        tcm_psel,
  output var  logic        tcm_penable,
  output var  logic        tcm_pwrite,
  output var  logic [31:0] tcm_pwdata,
  input  wire logic        tcm_pready,
  input  wire logic        tcm_pslverr,
  // Status outputs
  output var  logic        copy_active_out,
  output var  logic        copy_irq_out
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  localparam logic [31:0] BLOCK_BASE = ESS_BASE + WCD_BLOCK_OFFSET;

  if (WRITE_PORT != 0 && WRITE_PORT != 1) begin : g_bad_port
    $error("WRITE_PORT must be 0 or 1");
  end
  if (BLOCK_BASE[WCD_REG_AW-1:0] != '0) begin : g_bad_base
    $error("Block base must be aligned to the register window");
  end

  // ----------------------------------------------------------------------
  // Register target decode
  // ----------------------------------------------------------------------
  logic        hit;
  logic [4:0]  off;
  logic        known;
  logic        wr_acc;
  logic        rd_setup;
  logic [1:0]  ctrl_q;
  logic [1:0]  irqc_q;
  logic        error_q;
  logic [31:0] src_start_q;
  logic [31:0] dst_start_q;
  logic [31:0] size_q;
  logic [31:0] prdata_q;
  wcd_state_t  state_q;

  assign hit      = paddr[31:WCD_REG_AW] == BLOCK_BASE[31:WCD_REG_AW];
  assign off      = paddr[WCD_REG_AW-1:0];
  assign known    = hit && (off == WCD_OFF_CONTROL || off == WCD_OFF_IRQ_CFG || off == WCD_OFF_STATE
                    || off == WCD_OFF_SOURCE || off == WCD_OFF_DEST || off == WCD_OFF_COUNT);
  assign wr_acc   = psel && penable && pwrite && known;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !known;
  assign prdata   = prdata_q;

  logic go_wr;
  logic abort_wr;
  assign abort_wr = wr_acc && off == WCD_OFF_CONTROL && pwdata[WCD_BIT_ABORT];
  assign go_wr    = wr_acc && off == WCD_OFF_CONTROL && pwdata[WCD_BIT_GO] && !abort_wr;

  // Writes to the status word fall through every case and change nothing.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_q      <= WCD_CTRL_RESET;
      irqc_q      <= WCD_IRQC_RESET;
      src_start_q <= WCD_WORD_RESET;
      dst_start_q <= WCD_WORD_RESET;
      size_q      <= WCD_WORD_RESET;
    end else if (wr_acc) begin
      unique case (off)
        WCD_OFF_CONTROL: ctrl_q      <= pwdata[1:0];
        WCD_OFF_IRQ_CFG: irqc_q      <= pwdata[1:0];
        WCD_OFF_SOURCE:  src_start_q <= pwdata;
        WCD_OFF_DEST:    dst_start_q <= pwdata;
        WCD_OFF_COUNT:   size_q      <= pwdata;
        default:         ctrl_q      <= ctrl_q;
      endcase
    end
  end

  // Read data is captured in the setup phase so that it leaves a flip-flop.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata_q <= WCD_WORD_RESET;
    end else if (rd_setup) begin
      prdata_q <= WCD_WORD_RESET;
      if (hit) begin
        unique case (off)
          WCD_OFF_CONTROL: prdata_q[1:0] <= ctrl_q;
          WCD_OFF_IRQ_CFG: prdata_q[1:0] <= irqc_q;
          WCD_OFF_STATE:   prdata_q[1:0] <= {error_q, copy_active_out};
          WCD_OFF_SOURCE:  prdata_q      <= src_start_q;
          WCD_OFF_DEST:    prdata_q      <= dst_start_q;
          WCD_OFF_COUNT:   prdata_q      <= size_q;
          default:         prdata_q      <= WCD_WORD_RESET;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Copy sequencer
  // ----------------------------------------------------------------------
  logic [31:0] src_addr_q;
  logic [31:0] dst_addr_q;
  logic [31:0] remain_q;
  logic [31:0] data_q;
  logic        advance;
  logic        last;
  logic        err_evt;
  logic        done_evt;

  assign advance  = (state_q == WCD_WR_DATA && dst_hready && !dst_hresp)
                 || (state_q == WCD_TCM_ACCESS && tcm_pready && !tcm_pslverr);
  assign last     = remain_q == WCD_ONE_WORD;
  assign err_evt  = !abort_wr && ((state_q == WCD_RD_DATA && src_hresp) || (state_q == WCD_WR_DATA && dst_hresp)
                 || (state_q == WCD_TCM_ACCESS && tcm_pready && tcm_pslverr));
  assign done_evt = !abort_wr && ((advance && last) || (go_wr && state_q == WCD_IDLE && size_q == '0));

  // An abort drops the engine to idle at once; a beat already accepted by
  // an AHB target completes on that bus without the engine watching it.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= WCD_IDLE;
    end else if (abort_wr || err_evt) begin
      state_q <= WCD_IDLE;
    end else begin
      unique case (state_q)
        WCD_IDLE:       if (go_wr && size_q != '0) state_q <= WCD_RD_ADDR;
        WCD_RD_ADDR:    if (src_hready) state_q <= WCD_RD_DATA;
        WCD_RD_DATA:    if (src_hready) state_q <= (WRITE_PORT == 1) ? WCD_WR_ADDR : WCD_TCM_SETUP;
        WCD_WR_ADDR:    if (dst_hready) state_q <= WCD_WR_DATA;
        WCD_WR_DATA:    if (advance) state_q <= last ? WCD_IDLE : WCD_RD_ADDR;
        WCD_TCM_SETUP:  state_q <= WCD_TCM_ACCESS;
        WCD_TCM_ACCESS: if (advance) state_q <= last ? WCD_IDLE : WCD_RD_ADDR;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      src_addr_q <= WCD_WORD_RESET;
      dst_addr_q <= WCD_WORD_RESET;
      remain_q   <= WCD_WORD_RESET;
    end else if (go_wr && state_q == WCD_IDLE) begin
      src_addr_q <= src_start_q;
      dst_addr_q <= dst_start_q;
      remain_q   <= size_q;
    end else if (advance) begin
      src_addr_q <= src_addr_q + WCD_ADDR_STEP;
      dst_addr_q <= dst_addr_q + WCD_ADDR_STEP;
      remain_q   <= remain_q - WCD_ONE_WORD;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      data_q <= WCD_WORD_RESET;
    end else if (state_q == WCD_RD_DATA && src_hready && !src_hresp) begin
      data_q <= src_hrdata;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags and interrupt
  // ----------------------------------------------------------------------
  // The interrupt is a level that holds until the next start or abort.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      error_q      <= 1'b0;
      copy_irq_out <= 1'b0;
    end else begin
      if (err_evt) begin
        error_q <= 1'b1;
      end else if (go_wr && state_q == WCD_IDLE) begin
        error_q <= 1'b0;
      end
      if (err_evt || (done_evt && irqc_q[WCD_BIT_IRQ_ALL])) begin
        copy_irq_out <= 1'b1;
      end else if ((go_wr && state_q == WCD_IDLE) || abort_wr) begin
        copy_irq_out <= 1'b0;
      end
    end
  end

  assign copy_active_out = state_q != WCD_IDLE;

  // ----------------------------------------------------------------------
  // Initiator outputs
  // ----------------------------------------------------------------------
  assign src_haddr  = src_addr_q;
  assign src_htrans = (state_q == WCD_RD_ADDR) ? WCD_HTRANS_NONSEQ : WCD_HTRANS_IDLE;
  assign src_hwrite = 1'b0;
  assign src_hsize  = WCD_HSIZE_WORD;
  assign src_hburst = WCD_HBURST_SINGLE;

  assign dst_haddr  = dst_addr_q;
  assign dst_htrans = (state_q == WCD_WR_ADDR) ? WCD_HTRANS_NONSEQ : WCD_HTRANS_IDLE;
  assign dst_hwrite = 1'b1;
  assign dst_hsize  = WCD_HSIZE_WORD;
  assign dst_hburst = WCD_HBURST_SINGLE;
  assign dst_hwdata = data_q;

  // The memory-port initiator only ever writes; it has no read path.
  assign tcm_paddr   = dst_addr_q;
  assign tcm_psel    = state_q == WCD_TCM_SETUP || state_q == WCD_TCM_ACCESS;
  assign tcm_penable = state_q == WCD_TCM_ACCESS;
  assign tcm_pwrite  = 1'b1;
  assign tcm_pwdata  = data_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_start_goes_busy: assert property (go_wr && !copy_active_out && size_q != '0 |=> copy_active_out)
    else $error("Start did not make the engine busy");
  a_abort_idles: assert property (abort_wr |=> !copy_active_out && !copy_irq_out)
    else $error("Abort did not stop the copy");
  a_addr_step: assert property (advance && !last |=> src_haddr == $past(src_haddr) + WCD_ADDR_STEP
                                && dst_haddr == $past(dst_haddr) + WCD_ADDR_STEP)
    else $error("Addresses did not step by one word");
  a_last_drops_busy: assert property (advance && last && !abort_wr |=> !copy_active_out)
    else $error("Busy stayed high after the last word");
  a_err_flags: assert property (err_evt |=> copy_irq_out && error_q && !copy_active_out)
    else $error("Bus error not reported");
  a_done_irq_cfg: assert property (done_evt && irqc_q[WCD_BIT_IRQ_ALL] |=> copy_irq_out)
    else $error("Completion interrupt missing");
  a_done_no_irq: assert property (done_evt && !irqc_q[WCD_BIT_IRQ_ALL] && !err_evt && !copy_irq_out
                                  |=> !copy_irq_out)
    else $error("Completion raised interrupt while disabled");
  a_read_beat: assert property (src_htrans == WCD_HTRANS_NONSEQ && !src_hready |=>
                                src_htrans == WCD_HTRANS_NONSEQ && $stable(src_haddr) || !copy_active_out)
    else $error("Source address phase changed while stalled");
  a_tcm_phases: assert property (tcm_psel && !tcm_penable |=> tcm_psel && tcm_penable && $stable(tcm_paddr)
                                 || !copy_active_out)
    else $error("Memory port setup not followed by access");
  a_status_busy: assert property (rd_setup && hit && off == WCD_OFF_STATE |=>
                                  prdata[WCD_BIT_BUSY] == $past(copy_active_out)
                                  && prdata[WCD_BIT_ERROR] == $past(error_q))
    else $error("Status read does not show busy and error");

endmodule // wcd_word_copy_dma

`default_nettype wire

// ===== wcd_ahb_mem.sv
// AHB-Lite target memory used on both copy engine initiator ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module wcd_ahb_mem (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Bus from the initiator
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  // Test controls
  input  wire logic [1:0]  slow,
  input  wire logic        err_en,
  input  wire logic [31:0] err_addr,
  // Response
  output var  logic [31:0] hrdata,
  output var  logic        hready,
  output var  logic        hresp
);
  logic [31:0] mem [0:63];
  logic [31:0] addr_q;
  logic [31:0] noise_q;
  logic [1:0]  wait_q;
  logic        pend_q;
  logic        wr_q;
  logic        err1_q;
  logic        hit;
  assign hit = pend_q && wait_q == 2'h0 && err_en && addr_q == err_addr;
  // Read data outside a data phase keeps changing so that stale data is never mistaken for a word.
  always_comb begin
    hready = !pend_q || (wait_q == 2'h0 && (!hit || err1_q));
    hresp  = hit;
    hrdata = (pend_q && wait_q == 2'h0 && !wr_q) ? {addr_q[15:0], ~addr_q[15:0]} : noise_q;
  end
  // Errors take the two-cycle response that the protocol demands.
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pend_q  <= 1'b0;
      wait_q  <= 2'h0;
      err1_q  <= 1'b0;
      noise_q <= 32'h0;
    end else begin
      noise_q <= ~noise_q + 32'h1357_9BDF;
      if (hready) begin
        if (pend_q && wr_q && !hit) mem[addr_q[7:2]] <= hwdata;
        pend_q <= htrans == 2'h2;
        addr_q <= haddr;
        wr_q   <= hwrite;
        wait_q <= slow;
        err1_q <= 1'b0;
      end else if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else begin
        err1_q <= 1'b1;
      end
    end
  end
endmodule // wcd_ahb_mem
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the word copy engine with the AHB-Lite and the memory-port destinations.
// Assumes three wcd_ahb_mem models as source and destination targets.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import wcd_pkg::*;
  localparam logic [31:0] ESS_BASE = 32'h2000_0000;
  localparam logic [31:0] RB       = ESS_BASE + WCD_BLOCK_OFFSET;
  logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic tcm_pready = 1'b1, tcm_pslverr = 1'b0, s_err = 1'b0, d_err = 1'b0, errv;
  logic [31:0] t_haddr, t_hrdata, t_paddr, t_pwdata;
  logic [31:0] tmem [64];
  logic [1:0]  t_htrans;
  logic t_hwrite, t_hready, t_hresp, t_psel, t_penable, t_pwrite, t_active, t_irq, t_pslv;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, e_addr = 32'h0, rdv, prdata, src_haddr, src_hrdata;
  logic [31:0] dst_haddr, dst_hwdata, tcm_paddr, tcm_pwdata, v;
  logic pready, pslverr, src_hwrite, src_hready, src_hresp, dst_hwrite, dst_hready, dst_hresp;
  logic tcm_psel, tcm_penable, tcm_pwrite, copy_active_out, copy_irq_out;
  logic [1:0] src_htrans, dst_htrans, slow = 2'h0;
  logic [2:0] src_hsize, src_hburst, dst_hsize, dst_hburst;
  logic [4:0] offs [3] = '{WCD_OFF_SOURCE, WCD_OFF_DEST, WCD_OFF_COUNT};
  int fail_count = 0, n_checks = 0, seed = 38;
  always #4 clk_sys = ~clk_sys;
  wcd_word_copy_dma #(.WRITE_PORT(1), .ESS_BASE(ESS_BASE)) dut_u (
    .clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .src_haddr, .src_htrans, .src_hwrite, .src_hsize, .src_hburst, .src_hrdata, .src_hready, .src_hresp,
    .dst_haddr, .dst_htrans, .dst_hwrite, .dst_hsize, .dst_hburst, .dst_hwdata, .dst_hready, .dst_hresp,
    .tcm_paddr, .tcm_psel, .tcm_penable, .tcm_pwrite, .tcm_pwdata, .tcm_pready, .tcm_pslverr,
    .copy_active_out, .copy_irq_out);
  wcd_ahb_mem src_m (.clk_sys, .reset_n, .haddr(src_haddr), .htrans(src_htrans), .hwrite(src_hwrite),
    .hwdata(32'h0), .slow, .err_en(s_err), .err_addr(e_addr), .hrdata(src_hrdata), .hready(src_hready),
    .hresp(src_hresp));
  wcd_ahb_mem dst_m (.clk_sys, .reset_n, .haddr(dst_haddr), .htrans(dst_htrans), .hwrite(dst_hwrite),
    .hwdata(dst_hwdata), .slow, .err_en(d_err), .err_addr(e_addr), .hrdata(), .hready(dst_hready),
    .hresp(dst_hresp));
  // Second engine built for the memory-port destination, fed the same register writes.
  wcd_word_copy_dma #(.WRITE_PORT(0), .ESS_BASE(ESS_BASE)) dut_t (
    .clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(),
    .src_haddr(t_haddr), .src_htrans(t_htrans), .src_hwrite(t_hwrite), .src_hsize(), .src_hburst(),
    .src_hrdata(t_hrdata), .src_hready(t_hready), .src_hresp(t_hresp),
    .dst_haddr(), .dst_htrans(), .dst_hwrite(), .dst_hsize(), .dst_hburst(), .dst_hwdata(),
    .dst_hready(1'b1), .dst_hresp(1'b0),
    .tcm_paddr(t_paddr), .tcm_psel(t_psel), .tcm_penable(t_penable), .tcm_pwrite(t_pwrite),
    .tcm_pwdata(t_pwdata), .tcm_pready, .tcm_pslverr(t_pslv),
    .copy_active_out(t_active), .copy_irq_out(t_irq));
  wcd_ahb_mem t_src (.clk_sys, .reset_n, .haddr(t_haddr), .htrans(t_htrans), .hwrite(t_hwrite),
    .hwdata(32'h0), .slow, .err_en(s_err), .err_addr(e_addr), .hrdata(t_hrdata), .hready(t_hready),
    .hresp(t_hresp));
  // Tightly coupled memory model: zero wait, error on the planted address.
  assign t_pslv = d_err && t_paddr == e_addr;
  always @(posedge clk_sys) begin
    if (t_psel && t_penable && tcm_pready && !t_pslv) tmem[t_paddr[7:2]] <= t_pwdata;
  end
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] ew(logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  task automatic check(string n, logic [31:0] seen, logic [31:0] e);
    n_checks++;
    if (seen !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Read data and error are taken at the edge that ends the access phase.
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge clk_sys);
    #1 {psel, penable, pwrite, paddr, pwdata} = {1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    #1 penable = 1'b1;
    @(posedge clk_sys);
    rdv = prdata;
    errv = pslverr;
    check("pready", {31'h0, pready}, 32'h1);
    #1 {psel, penable} = 2'b00;
  endtask
  task automatic wr(logic [4:0] o, logic [31:0] d);
    apb(1'b1, RB + {27'h0, o}, d);
  endtask
  task automatic rchk(string n, logic [4:0] o, logic [31:0] e);
    apb(1'b0, RB + {27'h0, o}, 32'h0);
    check(n, rdv, e);
  endtask
  task automatic idle(int lim);
    for (int i = 0; i < lim && (copy_active_out | t_active) !== 1'b0; i++) @(posedge clk_sys);
    if ((copy_active_out | t_active) !== 1'b0) begin
      fail_count++;
      $display("unexpected busy: expected 0 seen 1 after wait");
      test_done();
    end
  endtask
  task automatic fill();
    for (int i = 0; i < 64; i++) begin
      dst_m.mem[i] = 32'hEEEE_0000 | 32'(i);
      tmem[i] = 32'hEEEE_0000 | 32'(i);
    end
  endtask
  // One block copy; es or ed plants a bus error on word k of source or destination.
  task automatic run(logic [31:0] s, logic [31:0] d, logic [31:0] n, logic cfg, logic es, logic ed, int k);
    int w;
    logic [31:0] e;
    fill();
    {s_err, d_err} = {es, ed};
    e_addr = (es ? s : d) + 32'(4 * k);
    wr(WCD_OFF_SOURCE, s);
    wr(WCD_OFF_DEST, d);
    wr(WCD_OFF_COUNT, n);
    wr(WCD_OFF_IRQ_CFG, {31'h0, cfg});
    wr(WCD_OFF_CONTROL, 32'h1);
    check("active", {31'h0, copy_active_out}, {31'h0, n != 32'h0});
    check("tcm active", {31'h0, t_active}, {31'h0, n != 32'h0});
    idle(400);
    w = (es | ed) ? k : int'(n);
    rchk("state", WCD_OFF_STATE, (es | ed) ? 32'h2 : 32'h0);
    check("irq", {31'h0, copy_irq_out}, {31'h0, cfg | es | ed});
    check("tcm irq", {31'h0, t_irq}, {31'h0, cfg | es | ed});
    for (int i = 0; i < 64; i++) begin
      e = (i >= d[7:2] && i < d[7:2] + w) ? ew(s + 32'(4 * (i - d[7:2]))) : 32'hEEEE_0000 | 32'(i);
      check("dest word", dst_m.mem[i], e);
      check("tcm word", tmem[i], e);
    end
    {s_err, d_err} = 2'b00;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 6; i++) rchk("reset value", 5'(4 * i), 32'h0);
    apb(1'b0, RB + 32'h18, 32'h0);
    check("hole data", rdv, 32'h0);
    check("hole error", {31'h0, errv}, 32'h1);
    apb(1'b0, RB + 32'h20, 32'h0);
    check("outside error", {31'h0, errv}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      wr(offs[i], v);
      rchk("reg value", offs[i], v);
    end
    wr(WCD_OFF_IRQ_CFG, 32'hFFFF_FFFF);
    rchk("irq config", WCD_OFF_IRQ_CFG, 32'h3);
    wr(WCD_OFF_STATE, 32'hFFFF_FFFF);
    rchk("state write", WCD_OFF_STATE, 32'h0);
    $display("test registers done");
    fill();
    slow = 2'h2;
    wr(WCD_OFF_SOURCE, 32'h0);
    wr(WCD_OFF_DEST, 32'h8000_0000);
    wr(WCD_OFF_COUNT, 32'h8);
    wr(WCD_OFF_CONTROL, 32'h1);
    repeat (6) @(posedge clk_sys);
    #1 wr(WCD_OFF_CONTROL, 32'h2);
    idle(4);
    rchk("abort state", WCD_OFF_STATE, 32'h0);
    check("abort irq", {31'h0, copy_irq_out}, 32'h0);
    check("abort tail", dst_m.mem[7], 32'hEEEE_0007);
    check("tcm abort tail", tmem[7], 32'hEEEE_0007);
    check("tcm abort irq", {31'h0, t_irq}, 32'h0);
    rchk("control", WCD_OFF_CONTROL, 32'h2);
    $display("test abort done");
    for (int t = 0; t < 8; t++) begin
      slow = 2'($random(seed));
      run($random(seed) & 32'hFFFF_FFFC, 32'h8000_0000 | ((32'($random(seed)) & 32'h1F) << 2),
          32'($random(seed)) & 32'h7, 1'($random(seed)), 1'b0, 1'b0, 0);
    end
    slow = 2'h0;
    run(32'h0000_1000, 32'h8000_00FC, 32'h1, 1'b1, 1'b0, 1'b0, 0);
    run(32'h0000_2000, 32'h8000_0000, 32'h0, 1'b1, 1'b0, 1'b0, 0);
    run(32'h0000_3000, 32'h8000_0010, 32'h4, 1'b0, 1'b1, 1'b0, 0);
    run(32'h0000_4000, 32'h8000_0020, 32'h4, 1'b1, 1'b0, 1'b1, 2);
    check("tcm idle", {31'h0, tcm_psel}, 32'h0);
    check("bus attrs", {17'h0, src_hwrite, src_hsize, src_hburst, dst_hwrite, dst_hsize, dst_hburst, t_pwrite},
          {17'h0, 1'b0, 3'h2, 3'h0, 1'b1, 3'h2, 3'h0, 1'b1});
    $display("test copies done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
